// File: logic/sfpg_pkg.sv
//=============================================================
// shared function port group constants
//=============================================================
// Overview of operation
// - low port, three bits, per-bit direction
// - reset clears low direction and latch
// - middle low pin edges set interrupt
// - lowest low pin selectable as interrupt
// - single port latch resets to one
// - single pin falling edge sets interrupt
// - single port reads latch or pin
// - single port reads only bit zero
// - wide port direction plus analog disable
// - reset makes wide pins digital inputs
// - selected channel becomes analog input
// - direction one drives wide latch bit
// - analog and output pins read latch, inputs level
// - latch never driven onto analog pin
// - input-mode bits read pin level
// - pins sampled at the read access
// - pins change right after the write
// - select bit zero port, one interrupt
package sfpg_pkg;

  //===========================================================
  // register offsets
  //===========================================================
  localparam logic [7:0] LOW_LATCH_ADDR   = 8'h01;
  localparam logic [7:0] SINGLE_LATCH_ADDR = 8'h02;
  localparam logic [7:0] WIDE_LATCH_ADDR  = 8'h03;
  localparam logic [7:0] LOW_DIR_ADDR     = 8'h09;
  localparam logic [7:0] WIDE_DIR_ADDR    = 8'h0a;
  localparam logic [7:0] SINGLE_PIN_ADDR  = 8'h0d;
  localparam logic [7:0] CONV_CTRL_ADDR   = 8'h0e;
  localparam logic [7:0] IRQ_CTRL_ADDR    = 8'h37;

  //===========================================================
  // field positions
  //===========================================================
  localparam int CONV_DISABLE_BIT  = 4;
  localparam int CONV_SEL_LSB      = 0;
  localparam int IRQ_NOISE_BIT     = 7;
  localparam int IRQ_ZERO_SEL_BIT  = 6;
  localparam int IRQ_ONE_EDGE_BIT  = 1;

  //===========================================================
  // reset values
  //===========================================================
  localparam logic [2:0] LOW_DIR_RST      = 3'h0;
  localparam logic [2:0] LOW_LATCH_RST    = 3'h0;
  localparam logic       SINGLE_LATCH_RST = 1'b1;
  localparam logic [7:0] WIDE_DIR_RST     = 8'h00;
  localparam logic [7:0] WIDE_LATCH_RST   = 8'h00;
  localparam logic       CONV_DISABLE_RST = 1'b1;
  localparam logic [3:0] CONV_SEL_RST     = 4'h0;
  localparam logic [7:0] IRQ_CTRL_RST     = 8'h00;

endpackage

// File: logic/sfpg_edge_det.sv
`timescale 1ns/1ps
// edge detector per bit; pins are taken as synchronous to clk_sys
module sfpg_edge_det #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] level,
  input  wire logic [WIDTH-1:0] rise_en,
  input  wire logic [WIDTH-1:0] fall_en,
  output logic      [WIDTH-1:0] pulse
);

  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] prev_next;
  logic             armed_reg;
  logic             armed_next;

  always_comb begin
    prev_next  = level;
    armed_next = 1'b1;
  end

  // pulses wait until one real level has been sampled after reset,
  // so a pin that idles high gives no false edge at release
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_reg  <= '0;
      armed_reg <= 1'b0;
    end else begin
      prev_reg  <= prev_next;
      armed_reg <= armed_next;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign pulse[i] = armed_reg &
                        ((rise_en[i] & level[i] & ~prev_reg[i]) |
                         (fall_en[i] & ~level[i] & prev_reg[i]));
    end
  endgenerate

endmodule

// File: logic/sfpg_port_group.sv
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module sfpg_port_group #(
  parameter int LOW_W  = 3,
  parameter int WIDE_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic [LOW_W-1:0]  low_pin_in,
  output logic      [LOW_W-1:0]  low_pin_out,
  output logic      [LOW_W-1:0]  low_pin_oe,
  input  wire logic [LOW_W-1:0]  low_alt_out,
  input  wire logic              single_pin_in,
  output logic                   single_pin_out,
  output logic                   single_pin_oe,
  input  wire logic [WIDE_W-1:0] wide_pin_in,
  output logic      [WIDE_W-1:0] wide_pin_out,
  output logic      [WIDE_W-1:0] wide_pin_oe,
  input  wire logic [WIDE_W-1:0] wide_alt_out,
  output logic                   analog_input_disable,
  output logic      [3:0]        analog_channel_select,
  output logic      [WIDE_W-1:0] wide_analog_mask,
  output logic                   irq_zero_event,
  output logic                   irq_one_event,
  output logic                   irq_single_event
);

  //===========================================================
  // register state
  //===========================================================
  logic [LOW_W-1:0]  low_port_direction_reg;
  logic [LOW_W-1:0]  low_port_direction_next;
  logic [LOW_W-1:0]  low_port_latch_reg;
  logic [LOW_W-1:0]  low_port_latch_next;
  logic              single_port_latch_reg;
  logic              single_port_latch_next;
  logic [WIDE_W-1:0] wide_port_direction_reg;
  logic [WIDE_W-1:0] wide_port_direction_next;
  logic [WIDE_W-1:0] wide_port_latch_reg;
  logic [WIDE_W-1:0] wide_port_latch_next;
  logic              conv_disable_reg;
  logic              conv_disable_next;
  logic [3:0]        conv_select_reg;
  logic [3:0]        conv_select_next;
  logic              irq_noise_reg;
  logic              irq_noise_next;
  logic              irq_zero_sel_reg;
  logic              irq_zero_sel_next;
  logic              irq_one_edge_reg;
  logic              irq_one_edge_next;
  logic [7:0]        rdata_reg;
  logic [7:0]        rdata_next;

  logic [WIDE_W-1:0] low_view;
  logic [WIDE_W-1:0] wide_view;
  logic [7:0]        irq_ctrl_view;

  //===========================================================
  // register writes
  //===========================================================
  always_comb begin
    low_port_direction_next  = low_port_direction_reg;
    low_port_latch_next      = low_port_latch_reg;
    single_port_latch_next   = single_port_latch_reg;
    wide_port_direction_next = wide_port_direction_reg;
    wide_port_latch_next     = wide_port_latch_reg;
    conv_disable_next        = conv_disable_reg;
    conv_select_next         = conv_select_reg;
    irq_noise_next           = irq_noise_reg;
    irq_zero_sel_next        = irq_zero_sel_reg;
    irq_one_edge_next        = irq_one_edge_reg;
    if (reg_wr) begin
      // narrow ports keep only their implemented bits
      if (reg_addr == sfpg_pkg::LOW_LATCH_ADDR) begin
        low_port_latch_next = reg_wdata[LOW_W-1:0];
      end else if (reg_addr == sfpg_pkg::LOW_DIR_ADDR) begin
        low_port_direction_next = reg_wdata[LOW_W-1:0];
      end else if (reg_addr == sfpg_pkg::SINGLE_LATCH_ADDR) begin
        single_port_latch_next = reg_wdata[0];
      end else if (reg_addr == sfpg_pkg::WIDE_LATCH_ADDR) begin
        // analog pins still take the latch write, only the drive is held
        wide_port_latch_next = reg_wdata[WIDE_W-1:0];
      end else if (reg_addr == sfpg_pkg::WIDE_DIR_ADDR) begin
        wide_port_direction_next = reg_wdata[WIDE_W-1:0];
      end else if (reg_addr == sfpg_pkg::CONV_CTRL_ADDR) begin
        conv_disable_next = reg_wdata[sfpg_pkg::CONV_DISABLE_BIT];
        conv_select_next  = reg_wdata[sfpg_pkg::CONV_SEL_LSB +: 4];
      end else if (reg_addr == sfpg_pkg::IRQ_CTRL_ADDR) begin
        irq_noise_next    = reg_wdata[sfpg_pkg::IRQ_NOISE_BIT];
        irq_zero_sel_next = reg_wdata[sfpg_pkg::IRQ_ZERO_SEL_BIT];
        irq_one_edge_next = reg_wdata[sfpg_pkg::IRQ_ONE_EDGE_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      low_port_direction_reg  <= sfpg_pkg::LOW_DIR_RST;
      low_port_latch_reg      <= sfpg_pkg::LOW_LATCH_RST;
      single_port_latch_reg   <= sfpg_pkg::SINGLE_LATCH_RST;
      wide_port_direction_reg <= sfpg_pkg::WIDE_DIR_RST;
      wide_port_latch_reg     <= sfpg_pkg::WIDE_LATCH_RST;
      conv_disable_reg        <= sfpg_pkg::CONV_DISABLE_RST;
      conv_select_reg         <= sfpg_pkg::CONV_SEL_RST;
      irq_noise_reg           <= sfpg_pkg::IRQ_CTRL_RST[7];
      irq_zero_sel_reg        <= sfpg_pkg::IRQ_CTRL_RST[6];
      irq_one_edge_reg        <= sfpg_pkg::IRQ_CTRL_RST[1];
    end else begin
      low_port_direction_reg  <= low_port_direction_next;
      low_port_latch_reg      <= low_port_latch_next;
      single_port_latch_reg   <= single_port_latch_next;
      wide_port_direction_reg <= wide_port_direction_next;
      wide_port_latch_reg     <= wide_port_latch_next;
      conv_disable_reg        <= conv_disable_next;
      conv_select_reg         <= conv_select_next;
      irq_noise_reg           <= irq_noise_next;
      irq_zero_sel_reg        <= irq_zero_sel_next;
      irq_one_edge_reg        <= irq_one_edge_next;
    end
  end

  //===========================================================
  // analog channel decode
  //===========================================================
  // select codes beyond the wide port width pick no pin
  genvar gi;
  generate
    for (gi = 0; gi < WIDE_W; gi++) begin : g_analog
      assign wide_analog_mask[gi] = ~conv_disable_reg &
                                    (conv_select_reg == gi);
    end
  endgenerate

  assign analog_input_disable  = conv_disable_reg;
  assign analog_channel_select = conv_select_reg;

  //===========================================================
  // pin drive
  //===========================================================
  // function outputs are and-ed with the latch, so a latch left at
  // one hands the pin to the shared function
  assign low_pin_out = low_port_latch_reg & low_alt_out;
  assign low_pin_oe  = low_port_direction_reg &
                       ~{{(LOW_W-1){1'b0}}, irq_zero_sel_reg};
  // single pin is open drain: a latch of one releases it to input
  assign single_pin_out = 1'b0;
  assign single_pin_oe  = ~single_port_latch_reg;
  assign wide_pin_out   = wide_port_latch_reg & wide_alt_out;
  assign wide_pin_oe    = wide_port_direction_reg &
                          ~wide_analog_mask;

  //===========================================================
  // read paths
  //===========================================================
  assign low_view = {{(WIDE_W-LOW_W){1'b0}},
                     (low_port_direction_reg & low_port_latch_reg) |
                     (~low_port_direction_reg & low_pin_in)};
  assign wide_view = (wide_analog_mask & wide_port_latch_reg) |
                     (~wide_analog_mask & wide_port_direction_reg &
                      wide_port_latch_reg) |
                     (~wide_analog_mask & ~wide_port_direction_reg &
                      wide_pin_in);
  assign irq_ctrl_view = {irq_noise_reg, irq_zero_sel_reg, 4'h0,
                          irq_one_edge_reg, 1'b0};

  // pins are sampled on the edge that takes the read strobe
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      if (reg_addr == sfpg_pkg::LOW_LATCH_ADDR) begin
        rdata_next = low_view;
      end else if (reg_addr == sfpg_pkg::LOW_DIR_ADDR) begin
        rdata_next = {5'h00, low_port_direction_reg};
      end else if (reg_addr == sfpg_pkg::SINGLE_LATCH_ADDR) begin
        rdata_next = {7'h00, single_port_latch_reg};
      end else if (reg_addr == sfpg_pkg::SINGLE_PIN_ADDR) begin
        // upper bits are undefined to software; zero is given
        rdata_next = {7'h00, single_pin_in};
      end else if (reg_addr == sfpg_pkg::WIDE_LATCH_ADDR) begin
        rdata_next = wide_view;
      end else if (reg_addr == sfpg_pkg::WIDE_DIR_ADDR) begin
        rdata_next = wide_port_direction_reg;
      end else if (reg_addr == sfpg_pkg::CONV_CTRL_ADDR) begin
        rdata_next = {3'h0, conv_disable_reg, conv_select_reg};
      end else if (reg_addr == sfpg_pkg::IRQ_CTRL_ADDR) begin
        rdata_next = irq_ctrl_view;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  //===========================================================
  // external interrupt edges
  //===========================================================
  // detection looks at the pin itself, so a driven output still
  // raises its event; masking is the interrupt controller's job
  logic [2:0] edge_level;
  logic [2:0] edge_rise;
  logic [2:0] edge_fall;
  logic [2:0] edge_pulse;

  assign edge_level = {single_pin_in, low_pin_in[1], low_pin_in[0]};
  assign edge_rise  = {1'b0, ~irq_one_edge_reg, 1'b0};
  assign edge_fall  = {1'b1, irq_one_edge_reg, irq_zero_sel_reg};

  sfpg_edge_det #(
    .WIDTH (3)
  ) u_edge (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .level   (edge_level),
    .rise_en (edge_rise),
    .fall_en (edge_fall),
    .pulse   (edge_pulse)
  );

  assign irq_zero_event   = edge_pulse[0];
  assign irq_one_event    = edge_pulse[1];
  assign irq_single_event = edge_pulse[2];

  //===========================================================
  // assertions
  //===========================================================
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_low_dir_write: assert property (
    reg_wr && reg_addr == sfpg_pkg::LOW_DIR_ADDR |=>
      low_pin_oe[2:1] == $past(reg_wdata[2:1]))
    else $error("low direction write not applied");

  a_wide_drive_latch: assert property (
    reg_wr && reg_addr == sfpg_pkg::WIDE_LATCH_ADDR |=>
      ((wide_pin_out ^ ($past(reg_wdata) & wide_alt_out))
       & wide_pin_oe) == 8'h00)
    else $error("wide pin does not drive written latch");

  a_analog_no_drive: assert property (
    !analog_input_disable && analog_channel_select < 4'h8 |->
      !wide_pin_oe[analog_channel_select[2:0]])
    else $error("analog pin is driven");

  a_single_pin_read: assert property (
    reg_rd && reg_addr == sfpg_pkg::SINGLE_PIN_ADDR |=>
      reg_rdata == {7'h00, $past(single_pin_in)})
    else $error("single pin read wrong");

  a_wide_read_mix: assert property (
    reg_rd && reg_addr == sfpg_pkg::WIDE_LATCH_ADDR |=>
      reg_rdata == $past((wide_analog_mask & wide_port_latch_reg) |
        (~wide_analog_mask & ~wide_port_direction_reg & wide_pin_in) |
        (~wide_analog_mask & wide_port_direction_reg &
         wide_port_latch_reg)))
    else $error("wide read mix wrong");

  a_low_input_read: assert property (
    reg_rd && reg_addr == sfpg_pkg::LOW_LATCH_ADDR &&
    low_pin_oe == 3'h0 && !irq_zero_sel_reg |=>
      reg_rdata == {5'h00, $past(low_pin_in)})
    else $error("input bits must read pin");

  a_mid_fall_event: assert property (
    irq_one_edge_reg && $fell(low_pin_in[1]) && $past(resetn) |->
      irq_one_event)
    else $error("middle pin falling edge missed");

  a_single_fall_event: assert property (
    $fell(single_pin_in) && $past(resetn) |-> irq_single_event)
    else $error("single pin falling edge missed");

  a_zero_gated: assert property (
    !irq_zero_sel_reg |-> !irq_zero_event)
    else $error("zero event while pin is plain port");

  a_zero_input_only: assert property (
    irq_zero_sel_reg |-> !low_pin_oe[0])
    else $error("interrupt pin driven");

  a_zero_fall_event: assert property (
    irq_zero_sel_reg && $fell(low_pin_in[0]) && $past(resetn) |->
      irq_zero_event)
    else $error("zero pin falling edge missed");

  c_analog_read: cover property (
    !analog_input_disable && reg_rd &&
    reg_addr == sfpg_pkg::WIDE_LATCH_ADDR);
  c_mid_rise: cover property (irq_one_event && !irq_one_edge_reg);
  c_single_output_fall: cover property (
    single_pin_oe && irq_single_event);

endmodule

// File: tb/sfpg_board_model.sv
`timescale 1ns/1ps
//=============================================================
// board side: pull-ups plus optional external drivers
//=============================================================
module sfpg_board_model (
  input  wire logic [2:0] low_pin_out,
  input  wire logic [2:0] low_pin_oe,
  input  wire logic [2:0] low_ext,
  output logic      [2:0] low_pin_in,
  input  wire logic       single_pin_out,
  input  wire logic       single_pin_oe,
  input  wire logic       single_ext,
  output logic            single_pin_in,
  input  wire logic [7:0] wide_pin_out,
  input  wire logic [7:0] wide_pin_oe,
  input  wire logic [7:0] wide_ext,
  output logic      [7:0] wide_pin_in
);
  // the board drives a pin only where the device leaves it free;
  // low_ext of 1 stands in for the pull-up
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      low_pin_in[i] = low_pin_oe[i] ? low_pin_out[i] : low_ext[i];
    end
    // open drain: the device can only pull low
    single_pin_in = single_pin_oe ? single_pin_out : single_ext;
    for (int i = 0; i < 8; i++) begin
      wide_pin_in[i] = wide_pin_oe[i] ? wide_pin_out[i] : wide_ext[i];
    end
  end
endmodule

// File: tb/sfpg_port_group_tb.sv
`timescale 1ns/1ps
module sfpg_port_group_tb;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [2:0] low_pin_in, low_pin_out, low_pin_oe;
  logic       single_pin_in, single_pin_out, single_pin_oe;
  logic [7:0] wide_pin_in, wide_pin_out, wide_pin_oe, wide_analog_mask;
  logic       analog_input_disable;
  logic [3:0] analog_channel_select;
  logic       irq_zero_event, irq_one_event, irq_single_event;
  logic [2:0] low_ext = 3'h7;
  logic       single_ext = 1'b1;
  logic [7:0] wide_ext = 8'h3c;
  logic [2:0] low_alt = 3'h7;
  logic [7:0] wide_alt = 8'hff;
  int         err_count = 0;
  int         cmp_count = 0;
  int         ev0 = 0;
  int         ev1 = 0;
  int         evs = 0;
  int         b0, b1, bs;

  always #2.5 clk_sys = ~clk_sys;

  sfpg_port_group u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .low_pin_in(low_pin_in),
    .low_pin_out(low_pin_out), .low_pin_oe(low_pin_oe),
    .low_alt_out(low_alt), .single_pin_in(single_pin_in),
    .single_pin_out(single_pin_out), .single_pin_oe(single_pin_oe),
    .wide_pin_in(wide_pin_in), .wide_pin_out(wide_pin_out),
    .wide_pin_oe(wide_pin_oe), .wide_alt_out(wide_alt),
    .analog_input_disable(analog_input_disable),
    .analog_channel_select(analog_channel_select),
    .wide_analog_mask(wide_analog_mask),
    .irq_zero_event(irq_zero_event), .irq_one_event(irq_one_event),
    .irq_single_event(irq_single_event)
  );

  sfpg_board_model u_board (
    .low_pin_out(low_pin_out), .low_pin_oe(low_pin_oe),
    .low_ext(low_ext), .low_pin_in(low_pin_in),
    .single_pin_out(single_pin_out), .single_pin_oe(single_pin_oe),
    .single_ext(single_ext), .single_pin_in(single_pin_in),
    .wide_pin_out(wide_pin_out), .wide_pin_oe(wide_pin_oe),
    .wide_ext(wide_ext), .wide_pin_in(wide_pin_in)
  );

  // event pulses last one cycle, so count them at every edge
  always @(posedge clk_sys) begin
    if (irq_zero_event === 1'b1) ev0++;
    if (irq_one_event === 1'b1) ev1++;
    if (irq_single_event === 1'b1) evs++;
  end

  //===========================================================
  // bus tasks and compare
  //===========================================================
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check("rdata", reg_rdata, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    test_done();
  end

  //===========================================================
  // test sequence
  //===========================================================
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    settle();
    check("low_oe", {5'h0, low_pin_oe}, 8'h00);
    check("wide_oe", wide_pin_oe, 8'h00);
    check("mask", wide_analog_mask, 8'h00);
    check("disable", {7'h0, analog_input_disable}, 8'h01);
    check("single_oe", {7'h0, single_pin_oe}, 8'h00);
    rd_chk(8'h09, 8'h00);
    rd_chk(8'h01, 8'h07);
    rd_chk(8'h02, 8'h01);
    rd_chk(8'h0a, 8'h00);
    rd_chk(8'h03, 8'h3c);
    rd_chk(8'h0e, 8'h10);
    rd_chk(8'h37, 8'h00);
    // narrow, unmapped and read-only places
    wr(8'h09, 8'hff);
    rd_chk(8'h09, 8'h07);
    wr(8'h09, 8'h00);
    wr(8'h04, 8'h55);
    rd_chk(8'h04, 8'h00);
    wr(8'h0d, 8'h00);
    rd_chk(8'h02, 8'h01);
    // low port: latch preset to one before output mode
    wr(8'h01, 8'h07);
    wr(8'h09, 8'h02);
    check("low_oe", {5'h0, low_pin_oe}, 8'h02);
    check("low_out", {5'h0, low_pin_out}, 8'h07);
    check("single_out", {7'h0, single_pin_out}, 8'h00);
    low_alt <= 3'h5;
    settle();
    check("low_alt", {5'h0, low_pin_out}, 8'h05);
    low_alt <= 3'h7;
    settle();
    b1 = ev1;
    wr(8'h01, 8'h05);
    settle();
    check("ev1_fall", 8'(ev1 - b1), 8'h00);
    wr(8'h01, 8'h07);
    settle();
    check("ev1_rise", 8'(ev1 - b1), 8'h01);
    wr(8'h37, 8'h02);
    wr(8'h01, 8'h05);
    settle();
    check("ev1_fall", 8'(ev1 - b1), 8'h02);
    low_ext <= 3'h1;
    settle();
    rd_chk(8'h01, 8'h01);
    // lowest pin: port use, then interrupt use
    b0 = ev0;
    low_ext <= 3'h0;
    settle();
    low_ext <= 3'h1;
    settle();
    check("ev0_off", 8'(ev0 - b0), 8'h00);
    wr(8'h37, 8'h40);
    wr(8'h09, 8'h03);
    check("low_oe0", {7'h0, low_pin_oe[0]}, 8'h00);
    low_ext <= 3'h0;
    settle();
    check("ev0_on", 8'(ev0 - b0), 8'h01);
    wr(8'h37, 8'h00);
    wr(8'h09, 8'h00);
    // single port: latch and pin paths
    bs = evs;
    wr(8'h02, 8'hfe);
    check("single_oe", {7'h0, single_pin_oe}, 8'h01);
    settle();
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h0d, 8'h00);
    wr(8'h02, 8'h01);
    settle();
    single_ext <= 1'b0;
    settle();
    rd_chk(8'h0d, 8'h00);
    rd_chk(8'h02, 8'h01);
    check("evs", 8'(evs - bs), 8'h02);
    single_ext <= 1'b1;
    // wide port: mixed direction, then analog channel
    wr(8'h03, 8'h5a);
    wr(8'h0a, 8'h0f);
    check("wide_oe", wide_pin_oe, 8'h0f);
    check("wide_out", wide_pin_out & 8'h0f, 8'h0a);
    wide_alt <= 8'hf5;
    settle();
    check("wide_alt", wide_pin_out & 8'h0f, 8'h00);
    wide_alt <= 8'hff;
    settle();
    rd_chk(8'h03, 8'h3a);
    wr(8'h0e, 8'h05);
    check("mask", wide_analog_mask, 8'h20);
    check("sel", {4'h0, analog_channel_select}, 8'h05);
    check("disable", {7'h0, analog_input_disable}, 8'h00);
    settle();
    rd_chk(8'h03, 8'h1a);
    // analog pin stays undriven despite direction and latch writes
    wr(8'h0a, 8'h2f);
    check("wide_oe", wide_pin_oe, 8'h0f);
    wr(8'h03, 8'h7a);
    check("wide_oe", wide_pin_oe, 8'h0f);
    rd_chk(8'h03, 8'h3a);
    wr(8'h0e, 8'h09);
    check("mask", wide_analog_mask, 8'h00);
    wr(8'h0e, 8'h10);
    wr(8'h0a, 8'h00);
    check("wide_oe", wide_pin_oe, 8'h00);
    settle();
    rd_chk(8'h03, 8'h3c);
    test_done();
  end
endmodule
